// *** lts_pkg.sv ***
/*
  lts_pkg: constants, register map, carrier types and state enums of the
  leak test supervisor. Assumes a single 200 MHz system clock.
*/
package lts_pkg;
  localparam int NCH    = 8;
  localparam int GRP_CH = 4;
  localparam int NGRP   = 2;
  localparam int DIGITS = 6;
  localparam int WIN    = 10;
  localparam int LVL_W  = 8;
  localparam int PROF_W = 4;

  localparam logic [23:0] CODE_DEFAULT = 24'h147369;
  localparam logic [3:0]  DIGIT_MAX    = 4'h9;

  localparam longint CLK_HZ     = 200000000;
  localparam longint BAD_TIME_S = 10;
  localparam longint BAD_CYC    = BAD_TIME_S * CLK_HZ;

  localparam logic [7:0] A_CFG  = 8'h00;
  localparam logic [7:0] A_LVL  = 8'h04;
  localparam logic [7:0] A_CHEN = 8'h08;
  localparam logic [7:0] A_PROF = 8'h0c;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_IRQ  = 8'h14;
  localparam logic [7:0] A_MASK = 8'h18;

  localparam logic [31:0] LVL_RST  = 32'h08040804;
  localparam logic [7:0]  CHEN_RST = 8'hff;

  localparam int IRQ_FSEQ = 0;
  localparam int IRQ_FCYC = 1;
  localparam int IRQ_PSEQ = 2;
  localparam int IRQ_PCYC = 3;
  localparam int IRQ_BAD  = 4;
  localparam int IRQ_OK   = 5;
  localparam int NIRQ     = 6;

  typedef struct packed {
    logic split;
    logic auto_boot;
    logic ext_sel;
  } lts_cfg_t;

  typedef struct packed {
    logic [LVL_W-1:0] pcyc;
    logic [LVL_W-1:0] pseq;
    logic [LVL_W-1:0] fcyc;
    logic [LVL_W-1:0] fseq;
  } lts_lvl_t;

  typedef struct packed {
    logic              req;
    logic              grp_only;
    logic              grp;
    logic [PROF_W-1:0] prof;
  } lts_plc_t;

  typedef struct packed {
    logic       strobe;
    logic       change;
    logic [3:0] digit;
  } lts_key_t;

  typedef enum logic [2:0] {C_IDLE, C_ENTER, C_CUR, C_NEW1, C_NEW2, C_BAD} lts_code_st_t;
  typedef enum logic [1:0] {OP_RESET, OP_STARTUP, OP_AUTO} lts_op_t;

  typedef struct packed {
    logic [3:0]        alarms;
    logic [PROF_W-1:0] prof1;
    logic [PROF_W-1:0] prof0;
    logic [NGRP-1:0]   busy;
    logic              code_bad;
    lts_op_t           op;
  } lts_stat_t;
endpackage

// *** lts_alarm.sv ***
/*
  lts_alarm: out-of-criterion counting for one measured quantity (flow or
  pressure). Assumes results arrive as a one-cycle strobe per finished cycle.
*/
`timescale 1ns/1ps
module lts_alarm (
  input  wire logic                      sys_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      res_valid,
  input  wire logic [lts_pkg::NCH-1:0]   res_chan,
  input  wire logic [lts_pkg::NCH-1:0]   res_fail,
  input  wire logic [lts_pkg::LVL_W-1:0] seq_lvl,
  input  wire logic [lts_pkg::LVL_W-1:0] cyc_lvl,
  output logic                           seq_alarm,
  output logic                           cyc_alarm
);
  import lts_pkg::*;

  logic [3:0]       hist_r [WIN];
  logic [3:0]       ptr_r;
  logic [6:0]       sum_r;
  logic [LVL_W-1:0] run_r [NCH];
  logic [NCH-1:0]   hit;
  logic [3:0]       nfail;

  function automatic logic [3:0] popc(input logic [NCH-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < NCH; i++) n = n + {3'h0, v[i]};
    return n;
  endfunction

  assign nfail = popc(res_chan & res_fail);

  // window of the last WIN cycles; the running sum drops the slot it overwrites
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < WIN; i++) hist_r[i] <= 4'h0;
      ptr_r <= 4'h0;
      sum_r <= 7'h00;
    end else if (res_valid) begin
      hist_r[ptr_r] <= nfail;
      ptr_r         <= (ptr_r == 4'(WIN - 1)) ? 4'h0 : ptr_r + 4'h1;
      sum_r         <= sum_r + 7'(nfail) - 7'(hist_r[ptr_r]);
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_run
    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        run_r[c] <= '0;
      end else if (res_valid && res_chan[c]) begin
        if (!res_fail[c]) run_r[c] <= '0;
        else if (run_r[c] != '1) run_r[c] <= run_r[c] + 1'b1;
      end
    end
    assign hit[c] = (cyc_lvl != '0) && (run_r[c] >= cyc_lvl);
  end

  // a level of zero disables the alarm
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_alarm <= 1'b0;
      cyc_alarm <= 1'b0;
    end else begin
      seq_alarm <= (seq_lvl != '0) && ({1'b0, sum_r} >= seq_lvl);
      cyc_alarm <= |hit;
    end
  end

  property p_run_clear;
    @(posedge sys_clk) disable iff (sys_rst)
      (res_valid && res_chan[0] && !res_fail[0]) |=> (run_r[0] == '0);
  endproperty
  a_run_clear: assert property (p_run_clear) else $error("run count not cleared on pass");

  property p_seq_level;
    @(posedge sys_clk) disable iff (sys_rst)
      (seq_lvl != '0 && $stable(seq_lvl) && {1'b0, sum_r} >= seq_lvl) |=> seq_alarm;
  endproperty
  a_seq_level: assert property (p_seq_level) else $error("sequential alarm missed");

  property p_sum_bound;
    @(posedge sys_clk) disable iff (sys_rst)
      res_valid |=> (sum_r <= 7'(WIN * NCH));
  endproperty
  a_sum_bound: assert property (p_sum_bound) else $error("window sum out of range");
endmodule // lts_alarm

// *** lts_supervisor.sv ***
/*
  lts_supervisor: access code, measurement mode and group sequencing,
  profile selection, alarm counting and power-up mode of a leak tester.
  Assumes keypad, start and controller pins are asynchronous; channel
  results and cycle-done strobes come from logic on sys_clk.
*/
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
//
// Contract
// - an access code is six decimal digits and is judged only when the sixth is keyed.
// - out of reset the stored code is 147369 until a change stores another.
// - a change takes current code, new code, new code again, and stores only if the two new ones match.
// - any wrong code shows the incorrect indication for 10 s and then returns to the main state.
// - in full-parallel mode all enabled channels, one to eight, run their phases together.
// - in split mode the channels form two groups of one to four channels.
// - in split mode each group's start is taken and sequenced regardless of the other group.
// - in split mode both groups use the selected profile unless an external command gives a group its own.
// - flow failures summed over all channels across the last ten cycles are compared with the flow sequential level.
// - each channel's run of consecutive flow failures is compared with the flow cycle level.
// - pressure failures summed over all channels across the last ten cycles are compared with the pressure sequential level.
// - each channel's run of consecutive pressure failures is compared with the pressure cycle level.
// - at power-up the automatic option sends the device straight to automatic mode, else to startup; the code always enters startup, as cfg_r still holds 0.
// - controller profile selection is taken only while the external-selection option is on.
// - sixteen profiles exist and a launched cycle applies the active profile.
module lts_supervisor #(
  parameter int unsigned BAD_CYCLES = 32'(lts_pkg::BAD_CYC)
) (
  input  wire logic                         sys_clk,
  input  wire logic                         sys_rst,
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [31:0]                  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic [31:0]                       reg_rdata,
  output logic                              irq,
  input  wire lts_pkg::lts_key_t            key_pin,
  input  wire logic [lts_pkg::NGRP-1:0]     start_pin,
  input  wire lts_pkg::lts_plc_t            plc_pin,
  input  wire logic [lts_pkg::NGRP-1:0]     cycle_done,
  input  wire logic                         res_valid,
  input  wire logic [lts_pkg::NCH-1:0]      res_chan,
  input  wire logic [lts_pkg::NCH-1:0]      res_flow_fail,
  input  wire logic [lts_pkg::NCH-1:0]      res_press_fail,
  output logic [lts_pkg::NCH-1:0]           chan_run,
  output logic [lts_pkg::PROF_W-1:0]        grp0_prof,
  output logic [lts_pkg::PROF_W-1:0]        grp1_prof,
  output logic                              access_ok,
  output logic                              code_bad,
  output lts_pkg::lts_op_t                  op_mode
);
  import lts_pkg::*;

  localparam int KW = $bits(lts_key_t);
  localparam int PW = $bits(lts_plc_t);

  lts_cfg_t          cfg_r;
  lts_lvl_t          lvl_r;
  logic [NCH-1:0]    chen_r;
  logic [PROF_W-1:0] prof_r;
  logic [NIRQ-1:0]   irq_stat_r;
  logic [NIRQ-1:0]   irq_mask_r;
  logic [NIRQ-1:0]   ev;
  logic [31:0]       rdata_nxt;

  logic [KW-1:0] key_s1_r, key_s2_r;
  logic [PW-1:0] plc_s1_r, plc_s2_r;
  logic [NGRP-1:0] st_s1_r, st_s2_r, st_d_r;
  lts_key_t key_s;
  lts_plc_t plc_s;
  logic key_d_r, plc_d_r;
  logic key_ev, plc_ev;
  logic [NGRP-1:0] start_ev;

  lts_code_st_t      cst_r;
  logic [23:0]       code_r, entry_r, new_r;
  logic [2:0]        ndig_r;
  logic [31:0]       bad_cnt_r;
  logic              six;
  logic [23:0]       full;

  logic [NGRP-1:0]   busy_r;
  logic [PROF_W-1:0] gprof_r [NGRP];
  logic [PROF_W-1:0] ovr_prof_r [NGRP];
  logic [NGRP-1:0]   ovr_r;
  logic [NGRP-1:0]   grp_has;
  logic [NGRP-1:0]   launch;
  logic              boot_done_r;
  logic [3:0]        alarm;

  // two-flop synchronisers on every pin input; edges are taken on stage two
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      key_s1_r <= '0;
      key_s2_r <= '0;
      plc_s1_r <= '0;
      plc_s2_r <= '0;
      st_s1_r  <= '0;
      st_s2_r  <= '0;
      st_d_r   <= '0;
      key_d_r  <= 1'b0;
      plc_d_r  <= 1'b0;
    end else begin
      key_s1_r <= key_pin;
      key_s2_r <= key_s1_r;
      plc_s1_r <= plc_pin;
      plc_s2_r <= plc_s1_r;
      st_s1_r  <= start_pin;
      st_s2_r  <= st_s1_r;
      st_d_r   <= st_s2_r;
      key_d_r  <= key_s.strobe;
      plc_d_r  <= plc_s.req;
    end
  end

  assign key_s    = lts_key_t'(key_s2_r);
  assign plc_s    = lts_plc_t'(plc_s2_r);
  assign key_ev   = key_s.strobe && !key_d_r && (key_s.digit <= DIGIT_MAX);
  assign plc_ev   = plc_s.req && !plc_d_r;
  assign start_ev = st_s2_r & ~st_d_r;

  // access code: digits shift in, the sixth one triggers the comparison
  assign six  = key_ev && (ndig_r == 3'(DIGITS - 1));
  assign full = {entry_r[19:0], key_s.digit};

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cst_r     <= C_IDLE;
      entry_r   <= '0;
      new_r     <= '0;
      ndig_r    <= '0;
      bad_cnt_r <= '0;
      access_ok <= 1'b0;
    end else begin
      access_ok <= 1'b0;
      if (key_ev && cst_r != C_BAD) begin
        entry_r <= full;
        ndig_r  <= six ? 3'h0 : ndig_r + 3'h1;
      end
      case (cst_r)
        C_IDLE: begin
          // the opening keystroke is digit one, so its count must survive here
          if (!key_ev) ndig_r <= '0;
          if (key_s.strobe && !key_d_r) cst_r <= key_s.change ? C_CUR : C_ENTER;
        end
        C_ENTER: if (six) begin
          if (full == code_r) begin
            access_ok <= 1'b1;
            cst_r     <= C_IDLE;
          end else cst_r <= C_BAD;
        end
        C_CUR:  if (six) cst_r <= (full == code_r) ? C_NEW1 : C_BAD;
        C_NEW1: if (six) begin
          new_r <= full;
          cst_r <= C_NEW2;
        end
        C_NEW2: if (six) cst_r <= (full == new_r) ? C_IDLE : C_BAD;
        C_BAD: begin
          ndig_r <= '0;
          if (bad_cnt_r == BAD_CYCLES - 1) begin
            bad_cnt_r <= '0;
            cst_r     <= C_IDLE;
          end else bad_cnt_r <= bad_cnt_r + 32'h1;
        end
        default: cst_r <= C_IDLE;
      endcase
    end
  end

  // the opening keystroke only picks the sequence; its digit is still counted
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) code_r <= CODE_DEFAULT;
    else if (cst_r == C_NEW2 && six && full == new_r) code_r <= new_r;
  end

  assign code_bad = (cst_r == C_BAD);

  // power-up mode is decided once, on the first edge after reset release
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_mode     <= OP_RESET;
      boot_done_r <= 1'b0;
    end else if (!boot_done_r) begin
      boot_done_r <= 1'b1;
      op_mode     <= cfg_r.auto_boot ? OP_AUTO : OP_STARTUP;
    end
  end

  // group sequencing; full-parallel mode drives everything through group 0
  assign grp_has[0] = cfg_r.split ? |chen_r[GRP_CH-1:0] : |chen_r;
  assign grp_has[1] = cfg_r.split && |chen_r[NCH-1:GRP_CH];
  assign launch[0]  = start_ev[0] && !busy_r[0] && grp_has[0];
  assign launch[1]  = start_ev[1] && !busy_r[1] && grp_has[1];

  for (genvar g = 0; g < NGRP; g++) begin : g_grp
    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        busy_r[g]  <= 1'b0;
        gprof_r[g] <= '0;
      end else if (launch[g]) begin
        busy_r[g]  <= 1'b1;
        gprof_r[g] <= (cfg_r.split && ovr_r[g]) ? ovr_prof_r[g] : prof_r;
      end else if (cycle_done[g]) begin
        busy_r[g]  <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) chan_run <= '0;
    else if (cfg_r.split) chan_run <= chen_r & {{GRP_CH{busy_r[1]}}, {GRP_CH{busy_r[0]}}};
    else chan_run <= chen_r & {NCH{busy_r[0]}};
  end

  assign grp0_prof = gprof_r[0];
  assign grp1_prof = gprof_r[1];

  // profile selection: software at any time, the controller only when allowed
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prof_r     <= '0;
      ovr_r      <= '0;
      ovr_prof_r <= '{default: '0};
    end else if (reg_wr && reg_addr == A_PROF) begin
      prof_r <= reg_wdata[PROF_W-1:0];
      ovr_r  <= '0;
    end else if (plc_ev && cfg_r.ext_sel) begin
      if (plc_s.grp_only) begin
        ovr_r[plc_s.grp]      <= 1'b1;
        ovr_prof_r[plc_s.grp] <= plc_s.prof;
      end else begin
        prof_r <= plc_s.prof;
        ovr_r  <= '0;
      end
    end
  end

  lts_alarm u_flow (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .res_valid (res_valid),
    .res_chan  (res_chan & chen_r),
    .res_fail  (res_flow_fail),
    .seq_lvl   (lvl_r.fseq),
    .cyc_lvl   (lvl_r.fcyc),
    .seq_alarm (alarm[IRQ_FSEQ]),
    .cyc_alarm (alarm[IRQ_FCYC])
  );

  lts_alarm u_press (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .res_valid (res_valid),
    .res_chan  (res_chan & chen_r),
    .res_fail  (res_press_fail),
    .seq_lvl   (lvl_r.pseq),
    .cyc_lvl   (lvl_r.pcyc),
    .seq_alarm (alarm[IRQ_PSEQ]),
    .cyc_alarm (alarm[IRQ_PCYC])
  );

  // register file
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_r      <= '0;
      lvl_r      <= LVL_RST;
      chen_r     <= CHEN_RST;
      irq_mask_r <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        A_CFG:   cfg_r      <= lts_cfg_t'(reg_wdata[$bits(lts_cfg_t)-1:0]);
        A_LVL:   lvl_r      <= lts_lvl_t'(reg_wdata);
        A_CHEN:  chen_r     <= reg_wdata[NCH-1:0];
        A_MASK:  irq_mask_r <= reg_wdata[NIRQ-1:0];
        default: ;
      endcase
    end
  end

  assign ev = {access_ok, (cst_r == C_BAD && bad_cnt_r == '0), alarm};

  // a new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) irq_stat_r <= '0;
    else if (reg_wr && reg_addr == A_IRQ) irq_stat_r <= (irq_stat_r & ~reg_wdata[NIRQ-1:0]) | ev;
    else irq_stat_r <= irq_stat_r | ev;
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  always_comb begin
    case (reg_addr)
      A_CFG:   rdata_nxt = 32'(cfg_r);
      A_LVL:   rdata_nxt = lvl_r;
      A_CHEN:  rdata_nxt = 32'(chen_r);
      A_PROF:  rdata_nxt = 32'(prof_r);
      A_STAT:  rdata_nxt = 32'(lts_stat_t'{alarm, gprof_r[1], gprof_r[0], busy_r, code_bad, op_mode});
      A_IRQ:   rdata_nxt = 32'(irq_stat_r);
      A_MASK:  rdata_nxt = 32'(irq_mask_r);
      default: rdata_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) reg_rdata <= '0;
    else if (reg_rd) reg_rdata <= rdata_nxt;
    else reg_rdata <= '0;
  end

  sequence s_cur_ok;
    cst_r == C_CUR && six && full == code_r;
  endsequence

  sequence s_mismatch;
    cst_r == C_NEW2 && six && full != new_r;
  endsequence

  property p_six_only;
    @(posedge sys_clk) disable iff (sys_rst)
      access_ok |-> $past(ndig_r) == 3'(DIGITS - 1);
  endproperty
  a_six_only: assert property (p_six_only) else $error("code judged before six digits");

  property p_code_store;
    @(posedge sys_clk) disable iff (sys_rst)
      !$stable(code_r) |-> $past(cst_r == C_NEW2 && six && full == new_r);
  endproperty
  a_code_store: assert property (p_code_store) else $error("code changed without match");

  property p_change_seq;
    @(posedge sys_clk) disable iff (sys_rst)
      s_cur_ok |=> cst_r == C_NEW1;
  endproperty
  a_change_seq: assert property (p_change_seq) else $error("change did not advance");

  property p_bad_entry;
    @(posedge sys_clk) disable iff (sys_rst)
      s_mismatch |=> code_bad ##1 code_bad;
  endproperty
  a_bad_entry: assert property (p_bad_entry) else $error("mismatch not flagged");

  property p_bad_end;
    @(posedge sys_clk) disable iff (sys_rst)
      (code_bad && bad_cnt_r == BAD_CYCLES - 1) |=> !code_bad && cst_r == C_IDLE;
  endproperty
  a_bad_end: assert property (p_bad_end) else $error("bad indication not ended");

  property p_boot;
    @(posedge sys_clk) disable iff (sys_rst)
      $rose(boot_done_r) |-> op_mode == (cfg_r.auto_boot ? OP_AUTO : OP_STARTUP);
  endproperty
  a_boot: assert property (p_boot) else $error("wrong power-up mode");

  property p_ext_off;
    @(posedge sys_clk) disable iff (sys_rst)
      (plc_ev && !cfg_r.ext_sel && !reg_wr) |=> $stable(prof_r) && $stable(ovr_r);
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("controller selection not ignored");

  property p_indep;
    @(posedge sys_clk) disable iff (sys_rst)
      (cfg_r.split && busy_r[0] && launch[1]) |=> busy_r[1] && busy_r[0] | $past(cycle_done[0]);
  endproperty
  a_indep: assert property (p_indep) else $error("group start not independent");

  property p_full_par;
    @(posedge sys_clk) disable iff (sys_rst)
      (!cfg_r.split && $stable(cfg_r)) |=> chan_run == (chen_r & {NCH{$past(busy_r[0])}}) || !$stable(chen_r);
  endproperty
  a_full_par: assert property (p_full_par) else $error("channels not run together");

  property p_launch_prof;
    @(posedge sys_clk) disable iff (sys_rst)
      (launch[0] && !(cfg_r.split && ovr_r[0])) |=> grp0_prof == $past(prof_r);
  endproperty
  a_launch_prof: assert property (p_launch_prof) else $error("launch used wrong profile");
endmodule // lts_supervisor

// *** lts_operator.sv ***
/*
  lts_operator: keypad and controller model facing the supervisor.
  Assumes the caller waits for each task to return before the next request.
*/
`timescale 1ns/1ps
module lts_operator (
  input  wire logic         sys_clk,
  output lts_pkg::lts_key_t key_pin,
  output lts_pkg::lts_plc_t plc_pin
);
  import lts_pkg::*;
  initial begin
    key_pin = '0;
    plc_pin = '0;
  end
  // strobe held several cycles so it survives the two-stage synchroniser
  task automatic press(input logic [3:0] d, input logic chg);
    @(posedge sys_clk) key_pin <= '{1'b0, chg, d};
    @(posedge sys_clk) key_pin.strobe <= 1'b1;
    repeat (5) @(posedge sys_clk);
    key_pin <= '{1'b0, 1'b0, ~d}; // released lines do not keep the last digit
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic code(input logic [23:0] c, input logic chg);
    for (int i = 5; i >= 0; i--) press(c[i*4 +: 4], chg && i == 5);
  endtask
  task automatic select(input logic go, input logic g, input logic [3:0] p);
    @(posedge sys_clk) plc_pin <= '{1'b0, go, g, p};
    @(posedge sys_clk) plc_pin.req <= 1'b1;
    repeat (5) @(posedge sys_clk);
    plc_pin.req <= 1'b0;
    repeat (5) @(posedge sys_clk);
  endtask
endmodule // lts_operator

// *** lts_supervisor_test.sv ***
/*
  lts_supervisor_test: self-checking bench of the supervisor.
  Assumes a short incorrect-code time (20 cycles) set by parameter.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module lts_supervisor_test;
  import lts_pkg::*;
  logic              sys_clk = 0;
  logic              sys_rst = 1;
  logic [7:0]        reg_addr = '0;
  logic [31:0]       reg_wdata = '0;
  logic              reg_wr = 0;
  logic              reg_rd = 0;
  logic [31:0]       reg_rdata;
  logic              irq;
  lts_key_t          key_pin;
  lts_plc_t          plc_pin;
  logic [1:0]        start_pin = '0;
  logic [1:0]        cycle_done = '0;
  logic              res_valid = 0;
  logic [7:0]        res_chan = '0;
  logic [7:0]        res_flow_fail = '0;
  logic [7:0]        res_press_fail = '0;
  logic [7:0]        chan_run;
  logic [3:0]        grp0_prof;
  logic [3:0]        grp1_prof;
  logic              access_ok;
  logic              code_bad;
  lts_op_t           op_mode;
  logic [31:0]       rv;
  int                n_mismatch = 0;
  int                checks_done = 0;
  int                n_ok = 0;
  int                n_bad = 0;
  int                cyc = 0;

  always #2.5 sys_clk = ~sys_clk;

  lts_supervisor #(.BAD_CYCLES(20)) u_lts_supervisor (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .key_pin(key_pin),
    .start_pin(start_pin), .plc_pin(plc_pin), .cycle_done(cycle_done), .res_valid(res_valid),
    .res_chan(res_chan), .res_flow_fail(res_flow_fail), .res_press_fail(res_press_fail),
    .chan_run(chan_run), .grp0_prof(grp0_prof), .grp1_prof(grp1_prof), .access_ok(access_ok),
    .code_bad(code_bad), .op_mode(op_mode));
  lts_operator u_lts_operator (.sys_clk(sys_clk), .key_pin(key_pin), .plc_pin(plc_pin));

  task automatic summarize;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // pulses are counted here so no one-cycle output is missed
  always @(posedge sys_clk) begin
    if (access_ok === 1'b1) n_ok++;
    if (code_bad === 1'b1) n_bad++;
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      summarize;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk) reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic start(input int g);
    @(posedge sys_clk) start_pin[g] <= 1'b1;
    repeat (5) @(posedge sys_clk);
    start_pin[g] <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic done(input int g);
    @(posedge sys_clk) cycle_done[g] <= 1'b1;
    @(posedge sys_clk) cycle_done[g] <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic res(input logic [7:0] ff, input logic [7:0] pf);
    @(posedge sys_clk) {res_valid, res_chan, res_flow_fail, res_press_fail} <= {1'b1, 8'h01, ff, pf};
    @(posedge sys_clk) res_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic t_reset;
    `CHK("op_mode", OP_STARTUP, op_mode)
    rd(A_LVL);
    `CHK("lvl", LVL_RST, rv)
    rd(8'h20);
    `CHK("unmapped", 32'h0, rv)
  endtask
  task automatic t_code;
    wr(A_MASK, 32'h10);
    u_lts_operator.code(CODE_DEFAULT, 1'b0);
    `CHK("ok", 1, n_ok)
    u_lts_operator.code(24'h147368, 1'b0);
    repeat (30) @(posedge sys_clk);
    `CHK("bad", 20, n_bad)
    `CHK("irq", 1'b1, irq)
    wr(A_IRQ, 32'h10);
    `CHK("irq clr", 1'b0, irq)
  endtask
  task automatic t_change;
    u_lts_operator.code(CODE_DEFAULT, 1'b1);
    u_lts_operator.code(24'h250814, 1'b0);
    u_lts_operator.code(24'h250814, 1'b0);
    u_lts_operator.code(24'h250814, 1'b0);
    `CHK("new ok", 2, n_ok)
    u_lts_operator.code(24'h250814, 1'b1);
    u_lts_operator.code(24'h111111, 1'b0);
    u_lts_operator.code(24'h222222, 1'b0);
    repeat (30) @(posedge sys_clk);
    `CHK("mismatch bad", 40, n_bad)
    u_lts_operator.code(24'h250814, 1'b0);
    `CHK("kept", 3, n_ok)
  endtask
  task automatic t_group;
    wr(A_PROF, 32'h5);
    start(1);
    `CHK("g1 full", 8'h00, chan_run)
    start(0);
    `CHK("full", 8'hff, chan_run)
    `CHK("prof0", 4'h5, grp0_prof)
    done(0);
    wr(A_CFG, 32'h5);
    wr(A_CHEN, 32'h3c);
    u_lts_operator.select(1'b1, 1'b1, 4'h9);
    start(0);
    `CHK("g0", 8'h0c, chan_run)
    start(1);
    `CHK("g0g1", 8'h3c, chan_run)
    `CHK("prof1", 4'h9, grp1_prof)
    `CHK("prof0s", 4'h5, grp0_prof)
    done(0);
    `CHK("g1 only", 8'h30, chan_run)
    done(1);
  endtask
  task automatic t_prof;
    wr(A_CFG, 32'h0);
    u_lts_operator.select(1'b0, 1'b0, 4'h7);
    rd(A_PROF);
    `CHK("ext off", 4'h5, rv[3:0])
    wr(A_CFG, 32'h1);
    u_lts_operator.select(1'b0, 1'b0, 4'h7);
    rd(A_PROF);
    `CHK("ext on", 4'h7, rv[3:0])
  endtask
  task automatic t_alarm;
    wr(A_CHEN, 32'hff);
    wr(A_LVL, 32'h06030603);
    repeat (3) res(8'h01, 8'h01);
    rd(A_STAT);
    `CHK("seq", 4'h5, rv[16:13])
    repeat (3) res(8'h01, 8'h01);
    rd(A_STAT);
    `CHK("cyc", 4'hf, rv[16:13])
    res(8'h00, 8'h00);
    rd(A_STAT);
    `CHK("pass", 4'h5, rv[16:13])
    wr(A_MASK, 32'h1);
    `CHK("alarm irq", 1'b1, irq)
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_reset;
    t_code;
    t_change;
    t_group;
    t_prof;
    t_alarm;
    summarize;
  end
endmodule // lts_supervisor_test
